/* hdl/mamc_consts.svh */
`ifndef MAMC_CONSTS_SVH
`define MAMC_CONSTS_SVH
`define MAMC_CFG_OFFSET        8'h09
`define MAMC_CFG_RESET         16'h0000
`define MAMC_BIT_NDS           14
`define MAMC_BIT_NDBT          13
`define MAMC_BIT_AUTO          12
`define MAMC_BIT_PDIFF0        10
`define MAMC_BIT_PDIFF1        11
`define MAMC_BIT_DIFF0         8
`define MAMC_BIT_DIFF1         9
`define MAMC_BIT_RANGE0        4
`define MAMC_BIT_FILT          3
`define MAMC_BIT_PINF_HI       2
`define MAMC_BIT_PINF_LO       1
`define MAMC_BIT_POL           0
`define MAMC_CLK_MHZ           200
`define MAMC_GLITCH_NS         50
`define MAMC_GLITCH_CYC        ((`MAMC_GLITCH_NS * `MAMC_CLK_MHZ + 999) / 1000)
`define MAMC_DELAY_MAX_NS      1000
`define MAMC_DELAY_MAX_CYC     ((`MAMC_DELAY_MAX_NS * `MAMC_CLK_MHZ) / 1000)
`endif

/* hdl/mamc_glitch.sv */
`timescale 1ns/1ps
`include "mamc_consts.svh"
module mamc_glitch (
  input  wire logic clk,     // clock
  input  wire logic rstn,    // sync reset, low
  input  wire logic bypass,  // 1: no filtering
  input  wire logic d,       // synced line
  output logic      q        // filtered line
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      q     <= 1'b1;
    end else if (bypass || d == q) begin // see RULE_07
      cnt_q <= 8'h00;
      if (bypass) q <= d;
    end else if (cnt_q >= 8'(`MAMC_GLITCH_CYC - 1)) begin // see RULE_07
      cnt_q <= 8'h00;
      q     <= d;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : mamc_glitch

/* hdl/mamc_pkg.sv */
package mamc_pkg;
  typedef enum logic [1:0] {
    MAMC_PIN_OFF,
    MAMC_PIN_BUSY,
    MAMC_PIN_ALERT,
    MAMC_PIN_CLEAR
  } mamc_pin_type;
  typedef enum logic [1:0] {
    MAMC_IDLE,
    MAMC_SAMPLE,
    MAMC_TRIALS
  } mamc_conv_type;
endpackage : mamc_pkg

/* hdl/mamc_sync.sv */
`timescale 1ns/1ps
module mamc_sync (
  input  wire logic clk,     // clock
  input  wire logic rstn,    // sync reset, low
  input  wire logic d,       // async input
  output logic      q        // synced output
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : mamc_sync

/* hdl/mamc_top.sv */
`timescale 1ns/1ps
`include "mamc_consts.svh"
// Functional notes
// RULE_01: host keeps bus quiet during conversions
// RULE_02: bit14 zero delays sampling during bus activity
// RULE_03: bit13 zero holds bit trials during activity
// RULE_04: bits 14, 13, 3 reset to zero
// RULE_05: bit14 one samples fixed to data line
// RULE_06: sampling delay over 1 us aborts
// RULE_07: bit3 zero filters pulses under 50 ns
// RULE_08: bit12 enables autocycle; bit15 reserved
// RULE_09: bits 8, 9 select differential pairs
// RULE_10: bits 10, 11 select pseudo-differential pairs
// RULE_11: bits 4 to 7 select wide ranges
// RULE_12: bit0 sets event pin polarity
// RULE_13: function 00 leaves event pin idle
// RULE_14: function 01 makes pin show busy
// RULE_15: function 10 makes pin show alert
// RULE_16: function 11 clears pin, flag, alerts
// RULE_17: after clear, function reads back 10
// RULE_18: whole register resets to zero
// RULE_19: host writes zero to bit15
module mamc_top (
  input  wire logic        clk,            // 200 MHz clock
  input  wire logic        rstn,           // sync reset, low
  input  wire logic        scl_in,         // serial clock pin
  input  wire logic        sda_in,         // serial data pin
  input  wire logic        cfg_wr,         // config write strobe
  input  wire logic [15:0] cfg_wdata,      // config write data
  input  wire logic        conv_start,     // conversion request
  input  wire logic        trials_done,    // bit trials finished
  input  wire logic        alert_event,    // limit violation pulse
  output logic      [15:0] cfg_rdata,      // config readback
  output logic             event_pin,      // shared event/busy pin
  output logic             alert_clear,    // clear flag and alerts pulse
  output logic             sample_now,     // sampling instant pulse
  output logic             trial_en,       // bit trials may run
  output logic             conv_abort,     // conversion abandoned pulse
  output logic             autocycle_en,   // autocycle mode
  output logic      [1:0]  diff_en,        // differential per pair
  output logic      [1:0]  pdiff_en,       // pseudo-diff per pair
  output logic      [3:0]  range_wide,     // doubled_reference_range per analog_input
  output logic             scl_filt,       // filtered serial clock
  output logic             sda_filt        // filtered serial data
);
  logic [15:0] cfg_q;
  logic        scl_s, sda_s, scl_f, sda_f, sda_f_q, scl_f_q;
  logic        bus_active;
  logic [7:0]  idle_cnt_q;
  logic [15:0] dly_cnt_q;
  logic        busy_q, alert_q, event_raw;
  logic        clr_wr;
  mamc_pkg::mamc_conv_type state_q;
  mamc_pkg::mamc_pin_type  pin_fn;

  mamc_sync u_sync_scl (.clk(clk), .rstn(rstn), .d(scl_in), .q(scl_s));
  mamc_sync u_sync_sda (.clk(clk), .rstn(rstn), .d(sda_in), .q(sda_s));
  mamc_glitch u_flt_scl (.clk(clk), .rstn(rstn), .bypass(cfg_q[`MAMC_BIT_FILT]),
                         .d(scl_s), .q(scl_f));
  mamc_glitch u_flt_sda (.clk(clk), .rstn(rstn), .bypass(cfg_q[`MAMC_BIT_FILT]),
                         .d(sda_s), .q(sda_f));

  assign clr_wr = cfg_wr && cfg_wdata[`MAMC_BIT_PINF_HI] && cfg_wdata[`MAMC_BIT_PINF_LO];

  // config register; clear code folds back to alert mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= `MAMC_CFG_RESET; // see RULE_18 see RULE_04
    end else if (cfg_wr) begin
      cfg_q <= cfg_wdata; // see RULE_08 see RULE_09 see RULE_10 see RULE_11
      if (clr_wr) cfg_q[`MAMC_BIT_PINF_LO] <= 1'b0; // see RULE_17
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) alert_clear <= 1'b0;
    else       alert_clear <= clr_wr; // see RULE_16
  end

  // bus activity: any filtered edge, held for a short quiet window
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sda_f_q    <= 1'b1;
      scl_f_q    <= 1'b1;
      idle_cnt_q <= 8'h00;
    end else begin
      sda_f_q <= sda_f;
      scl_f_q <= scl_f;
      if (sda_f != sda_f_q || scl_f != scl_f_q)
        idle_cnt_q <= 8'(`MAMC_GLITCH_CYC);
      else if (idle_cnt_q != 8'h00)
        idle_cnt_q <= idle_cnt_q - 8'h01;
    end
  end
  assign bus_active = (idle_cnt_q != 8'h00) || (sda_f != sda_f_q) || (scl_f != scl_f_q);

  // conversion sequencing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q    <= mamc_pkg::MAMC_IDLE;
      dly_cnt_q  <= 16'h0000;
      sample_now <= 1'b0;
      conv_abort <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      sample_now <= 1'b0;
      conv_abort <= 1'b0;
      case (state_q)
        mamc_pkg::MAMC_IDLE: begin
          dly_cnt_q <= 16'h0000;
          if (conv_start) begin
            state_q <= mamc_pkg::MAMC_SAMPLE;
            busy_q  <= 1'b1;
          end
        end
        mamc_pkg::MAMC_SAMPLE: begin
          if (cfg_q[`MAMC_BIT_NDS]) begin
            // fixed instant: sample on the first clk cycle in MAMC_SAMPLE, whatever the bus is doing
            sample_now <= 1'b1; // see RULE_05
            state_q    <= mamc_pkg::MAMC_TRIALS;
          end else if (!bus_active) begin
            sample_now <= 1'b1; // see RULE_02
            state_q    <= mamc_pkg::MAMC_TRIALS;
          end else if (dly_cnt_q >= 16'(`MAMC_DELAY_MAX_CYC)) begin
            conv_abort <= 1'b1; // see RULE_06
            busy_q     <= 1'b0;
            state_q    <= mamc_pkg::MAMC_IDLE;
          end else begin
            dly_cnt_q <= dly_cnt_q + 16'h0001;
          end
        end
        mamc_pkg::MAMC_TRIALS: begin
          if (trials_done) begin
            busy_q  <= 1'b0;
            state_q <= mamc_pkg::MAMC_IDLE;
          end
        end
        default: state_q <= mamc_pkg::MAMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) trial_en <= 1'b0;
    else trial_en <= (state_q == mamc_pkg::MAMC_TRIALS)
                     && (cfg_q[`MAMC_BIT_NDBT] || !bus_active); // see RULE_03
  end

  // alert latch; new event wins over clear
  always_ff @(posedge clk) begin
    if (!rstn)            alert_q <= 1'b0;
    else if (alert_event) alert_q <= 1'b1;
    else if (clr_wr)      alert_q <= 1'b0; // see RULE_16
  end

  assign pin_fn = mamc_pkg::mamc_pin_type'(cfg_q[`MAMC_BIT_PINF_HI:`MAMC_BIT_PINF_LO]);
  always_comb begin
    case (pin_fn)
      mamc_pkg::MAMC_PIN_BUSY:  event_raw = busy_q;  // see RULE_14
      mamc_pkg::MAMC_PIN_ALERT: event_raw = alert_q; // see RULE_15
      default:                  event_raw = 1'b0;    // see RULE_13
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      event_pin    <= 1'b1;
      cfg_rdata    <= `MAMC_CFG_RESET;
      autocycle_en <= 1'b0;
      diff_en      <= 2'h0;
      pdiff_en     <= 2'h0;
      range_wide   <= 4'h0;
      scl_filt     <= 1'b1;
      sda_filt     <= 1'b1;
    end else begin
      event_pin    <= cfg_q[`MAMC_BIT_POL] ? event_raw : !event_raw; // see RULE_12
      cfg_rdata    <= cfg_q;
      autocycle_en <= cfg_q[`MAMC_BIT_AUTO]; // see RULE_08
      diff_en      <= {cfg_q[`MAMC_BIT_DIFF1], cfg_q[`MAMC_BIT_DIFF0]}; // see RULE_09
      pdiff_en     <= {cfg_q[`MAMC_BIT_PDIFF1], cfg_q[`MAMC_BIT_PDIFF0]}; // see RULE_10
      range_wide   <= cfg_q[`MAMC_BIT_RANGE0 +: 4]; // see RULE_11
      scl_filt     <= scl_f;
      sda_filt     <= sda_f;
    end
  end

  property p_reset_zero;
    @(posedge clk)
      !rstn |=> cfg_q == `MAMC_CFG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see RULE_18
    else $error("config not zero after reset");

  property p_reset_features;
    @(posedge clk)
      !rstn |=> !cfg_q[`MAMC_BIT_NDS] && !cfg_q[`MAMC_BIT_NDBT] && !cfg_q[`MAMC_BIT_FILT];
  endproperty
  a_reset_features: assert property (p_reset_features) // see RULE_04
    else $error("noise features not enabled after reset");

  property p_clear_reads_alert;
    @(posedge clk) disable iff (!rstn)
      clr_wr |=> cfg_q[2:1] == 2'b10;
  endproperty
  a_clear_reads_alert: assert property (p_clear_reads_alert) // see RULE_17
    else $error("clear code not folded");

  property p_clear_pulse;
    @(posedge clk) disable iff (!rstn)
      clr_wr |=> alert_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) // see RULE_16
    else $error("clear pulse missing");

  property p_clear_drops_alert;
    @(posedge clk) disable iff (!rstn)
      clr_wr && !alert_event |=> !alert_q;
  endproperty
  a_clear_drops_alert: assert property (p_clear_drops_alert) // see RULE_16
    else $error("alert latch not cleared");

  property p_event_sets;
    @(posedge clk) disable iff (!rstn)
      alert_event |=> alert_q;
  endproperty
  a_event_sets: assert property (p_event_sets) // see RULE_15
    else $error("alert latch not set");

  // delay budget spent while the bus is still busy
  sequence s_delay_exhausted;
    state_q == mamc_pkg::MAMC_SAMPLE && !cfg_q[`MAMC_BIT_NDS] && bus_active
      && dly_cnt_q >= 16'(`MAMC_DELAY_MAX_CYC);
  endsequence

  sequence s_abort_seen;
    conv_abort && !busy_q && state_q == mamc_pkg::MAMC_IDLE;
  endsequence

  property p_abort_taken;
    @(posedge clk) disable iff (!rstn)
      s_delay_exhausted |=> s_abort_seen;
  endproperty
  a_abort_taken: assert property (p_abort_taken) // see RULE_06
    else $error("conversion not abandoned");

  property p_abort_bound;
    @(posedge clk) disable iff (!rstn)
      conv_abort |-> $past(dly_cnt_q) == 16'(`MAMC_DELAY_MAX_CYC);
  endproperty
  a_abort_bound: assert property (p_abort_bound) // see RULE_06
    else $error("abort early");

  property p_fixed_sample;
    @(posedge clk) disable iff (!rstn)
      state_q == mamc_pkg::MAMC_SAMPLE && cfg_q[`MAMC_BIT_NDS] |=> sample_now;
  endproperty
  a_fixed_sample: assert property (p_fixed_sample) // see RULE_05
    else $error("no fixed sample");

  property p_delay_sample;
    @(posedge clk) disable iff (!rstn)
      sample_now && !$past(cfg_q[`MAMC_BIT_NDS]) |-> !$past(bus_active);
  endproperty
  a_delay_sample: assert property (p_delay_sample) // see RULE_02
    else $error("sampled during bus");

  property p_trial_hold;
    @(posedge clk) disable iff (!rstn)
      state_q == mamc_pkg::MAMC_TRIALS && !cfg_q[`MAMC_BIT_NDBT] && bus_active |=> !trial_en;
  endproperty
  a_trial_hold: assert property (p_trial_hold) // see RULE_03
    else $error("bit trials during bus");

  property p_off_pin;
    @(posedge clk) disable iff (!rstn)
      pin_fn == mamc_pkg::MAMC_PIN_OFF |=> event_pin == !$past(cfg_q[`MAMC_BIT_POL]);
  endproperty
  a_off_pin: assert property (p_off_pin) // see RULE_13
    else $error("pin active when off");

  property p_busy_pin;
    @(posedge clk) disable iff (!rstn)
      pin_fn == mamc_pkg::MAMC_PIN_BUSY && cfg_q[`MAMC_BIT_POL] |=> event_pin == $past(busy_q);
  endproperty
  a_busy_pin: assert property (p_busy_pin) // see RULE_14
    else $error("busy pin wrong");

  property p_alert_pin;
    @(posedge clk) disable iff (!rstn)
      pin_fn == mamc_pkg::MAMC_PIN_ALERT && !cfg_q[`MAMC_BIT_POL] |=> event_pin == !$past(alert_q);
  endproperty
  a_alert_pin: assert property (p_alert_pin) // see RULE_15
    else $error("alert pin wrong");

  property p_autocycle;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> autocycle_en == $past(cfg_q[`MAMC_BIT_AUTO]);
  endproperty
  a_autocycle: assert property (p_autocycle) // see RULE_08
    else $error("autocycle output wrong");

  property p_diff;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> diff_en == $past({cfg_q[`MAMC_BIT_DIFF1], cfg_q[`MAMC_BIT_DIFF0]});
  endproperty
  a_diff: assert property (p_diff) // see RULE_09
    else $error("differential output wrong");

  property p_pdiff;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> pdiff_en == $past({cfg_q[`MAMC_BIT_PDIFF1], cfg_q[`MAMC_BIT_PDIFF0]});
  endproperty
  a_pdiff: assert property (p_pdiff) // see RULE_10
    else $error("pseudo-differential output wrong");

  property p_range;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> range_wide == $past(cfg_q[`MAMC_BIT_RANGE0 +: 4]);
  endproperty
  a_range: assert property (p_range) // see RULE_11
    else $error("range output wrong");
endmodule : mamc_top

/* tb/mamc_host_model.sv */
`timescale 1ns/1ps
module mamc_host_model (
  input  wire logic run,    // frame in progress
  input  wire logic glitch, // one narrow low pulse on data
  output logic      scl,    // serial clock line
  output logic      sda     // serial data line
);
  logic [1:0] ph     = 2'd0;
  logic       scl_q  = 1'b1;
  logic       sda_q  = 1'b1;
  logic       pull_q = 1'b0;
  assign scl = scl_q;
  assign sda = sda_q && !pull_q;
  // clock on even steps, data on every odd step: a line edge every 31.25 ns
  always begin
    #31.25;
    ph = ph + 2'd1;
    if (!run) begin
      scl_q = 1'b1; // pulled up, quiet outside frames
      sda_q = 1'b1;
    end else if (!ph[0]) begin
      scl_q = ~scl_q;
    end else begin
      sda_q = ~sda_q;
    end
  end
  always @(posedge glitch) begin
    pull_q = 1'b1;
    #30;
    pull_q = 1'b0;
  end
endmodule : mamc_host_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct {logic [1:0] s; logic [15:0] m; logic [15:0] e;} mamc_note_type;
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  logic          cfg_wr = 1'b0;
  logic [15:0]   cfg_wdata = 16'h0000;
  logic          conv_start = 1'b0;
  logic          trials_done = 1'b0;
  logic          alert_event = 1'b0;
  logic          run = 1'b0;
  logic          glitch = 1'b0;
  logic [15:0]   meas = 16'h0000;
  logic [15:0]   g;
  wire           scl;
  wire           sda;
  wire  [15:0]   rd;
  wire  [15:0]   obs;
  int            failures = 0;
  int            samples_checked = 0;
  mamc_note_type notes[$];
  mamc_note_type n;
  string         nm[3] = '{"cfg_rdata", "pins", "measure"};
  always #2.5 clk = ~clk;
  mamc_host_model host_u (.run(run), .glitch(glitch), .scl(scl), .sda(sda));
  mamc_top dut_u (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .conv_start(conv_start), .trials_done(trials_done),
    .alert_event(alert_event), .cfg_rdata(rd), .event_pin(obs[15]),
    .alert_clear(obs[14]), .sample_now(obs[13]), .trial_en(obs[12]),
    .conv_abort(obs[11]), .autocycle_en(obs[10]), .diff_en(obs[9:8]),
    .pdiff_en(obs[7:6]), .range_wide(obs[5:2]), .scl_filt(obs[1]), .sda_filt(obs[0]));
  always @(posedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      g = (n.s == 2'd0 ? rd : n.s == 2'd1 ? obs : meas) & n.m;
      samples_checked++;
      if (g !== n.e) begin
        failures++;
        $display("mismatch %s expected %h seen %h", nm[n.s], n.e, g);
      end
    end
  end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic note(input logic [1:0] s, input logic [15:0] m, input logic [15:0] e);
    notes.push_back('{s, m, e & m});
  endtask : note
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic sig);
    @(negedge clk);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
  endtask : pulse
  task automatic wr(input logic [15:0] d);
    logic [15:0] e;
    e = d;
    if (d[2:1] == 2'b11) e[2:1] = 2'b10;
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    note(1, 16'h4000, {1'b0, d[2:1] == 2'b11, 14'h0});
    cyc(2);
    note(0, 16'hFFFF, e);
    note(1, 16'h07FC, {5'h0, e[12], e[9:8], e[11:10], e[7:4], 2'h0});
    if (d[2] == d[1]) note(1, 16'h8000, {~d[0], 15'h0});
  endtask : wr
  task automatic wait_for(input int b, input logic v, input int lim, output int k);
    k = 0;
    while (obs[b] !== v) begin
      if (k == lim) begin
        failures++;
        $display("mismatch pins bit %0d expected %b seen %b", b, v, obs[b]);
        report_and_stop();
      end
      cyc(1);
      k++;
    end
    note(1, 16'h1 << b, {15'h0, v} << b);
  endtask : wait_for
  initial begin
    int k;
    logic [15:0] d;
    void'($urandom(27561));
    cyc(10);
    rstn = 1'b1;
    cyc(1);
    note(0, 16'hFFFF, 16'h0000);
    note(1, 16'hFFFF, 16'h8003);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom) & 16'h7FF8 | {13'h0, i[1:0], i[2]};
      wr(d);
    end
    wr(16'h0004);
    pulse(alert_event);
    wait_for(15, 1'b0, 8, k);
    wr(16'h0006);
    run = 1'b1;
    wr(16'h4002);
    pulse(conv_start);
    wait_for(13, 1'b1, 20, k);
    note(1, 16'h9000, 16'h0000);
    run = 1'b0;
    wait_for(12, 1'b1, 40, k);
    pulse(trials_done);
    wait_for(15, 1'b1, 8, k);
    wr(16'h0000);
    run = 1'b1;
    cyc(30);
    pulse(conv_start);
    wait_for(11, 1'b1, 260, k);
    meas = {15'h0, k >= 190};
    note(2, 16'h0001, 16'h0001);
    run = 1'b0;
    cyc(20);
    pulse(glitch);
    repeat (15) begin
      note(1, 16'h0001, 16'h0001);
      cyc(1);
    end
    wr(16'h0008);
    pulse(glitch);
    wait_for(0, 1'b0, 12, k);
    cyc(3);
    report_and_stop();
  end
endmodule : tb
